// ==== logic/canopen_dispatch_pkg.sv ====
/*
 * Constants of the CANopen dispatch logic: identifier bases,
 * SDO index window, APB offsets and reset values.
 * Assumes 125 MHz system clock.
 */
package canopen_dispatch_pkg;
    // Identifier space of standard frames
    localparam logic [10:0] ID_MAX = 11'h7EF;
    localparam logic [3:0] MAX_DLC = 4'h8;
    // Identifier bases added to the node number
    localparam logic [10:0] SDO_RX_BASE = 11'h600;
    localparam logic [10:0] SDO_TX_BASE = 11'h580;
    localparam logic [10:0] PDO1_RX_BASE = 11'h200;
    localparam logic [10:0] PDO1_TX_BASE = 11'h180;
    localparam logic [10:0] PDO2_RX_BASE = 11'h300;
    localparam logic [10:0] PDO2_TX_BASE = 11'h280;
    // Index window forwarded to the inverter control
    localparam logic [15:0] FWD_INDEX_LO = 16'h2000;
    localparam logic [15:0] FWD_INDEX_HI = 16'h5EFF;
    localparam logic [7:0] OVERRIDE_USE_ADDR = 8'hFF;
    // SDO command bytes
    localparam logic [2:0] CS_DOWNLOAD = 3'h1;
    localparam logic [2:0] CS_UPLOAD = 3'h2;
    localparam logic [7:0] RESP_WRITE = 8'h60;
    localparam logic [7:0] RESP_READ = 8'h43;
    localparam logic [7:0] RESP_ABORT = 8'h80;
    localparam logic [31:0] ABORT_CODE = 32'h0504_0001;
    // Local objects selected by subindex
    localparam logic [7:0] SUB_NODE = 8'h00;
    localparam logic [7:0] SUB_PDO = 8'h01;
    localparam logic [7:0] SUB_RATE = 8'h02;
    // Bit rate codes 0..9 = 10,20,25,50,100,125,250,500,800,1000 kbit/s
    localparam logic [3:0] RATE_CODE_MAX = 4'h9;
    // High-speed process data cycle
    localparam int CLK_HZ = 125_000_000;
    localparam int HS_CYCLE_MS = 3;
    localparam int HS_CYCLE_CYC = CLK_HZ / 1000 * HS_CYCLE_MS;
    // Mapping: inverter code offset into the forwarded range
    localparam logic [15:0] MAP_INDEX_BASE = 16'h2000;
    localparam logic [7:0] MAP_BIT_LEN = 8'h20;
    // APB register offsets
    localparam logic [7:0] REG_NODE_OVR = 8'h00;
    localparam logic [7:0] REG_INV_ADDR = 8'h04;
    localparam logic [7:0] REG_PDO_CTRL = 8'h08;
    localparam logic [7:0] REG_BIT_RATE = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_HS_MAP = 8'h14;
    localparam logic [7:0] REG_LS_MAP = 8'h18;
    // Reset values
    localparam logic [7:0] RST_NODE_OVR = 8'hFF;
    localparam logic [7:0] RST_INV_ADDR = 8'h01;
    localparam logic [2:0] RST_PDO_CTRL = 3'h0;
    localparam logic [3:0] RST_BIT_RATE = 4'h5;
    localparam logic [15:0] RST_LS_MAP = 16'h2000;
endpackage : canopen_dispatch_pkg

// ==== logic/canopen_id_dispatch.sv ====
/*
 * Message dispatch of a CANopen slave node: node number, identifier
 * assignment, SDO routing to local settings or to the inverter control,
 * and two PDO channels (high and low speed).
 * Assumes a CAN controller on this clock that arbitrates, and an
 * answering inverter control.
 */
// Summary of operation
// R1: Lowest identifier wins arbitration and completes its frame.
// R2: A loser of arbitration withdraws for now and receives.
// R3: Only identifiers 0 to 2031 are valid in standard frames.
// R4: A frame carries at most 8 data bytes.
// R5: Override 255 means node number is inverter address plus one.
// R6: Any other override value is used directly as node number.
// R7: SDO requests arrive on 1536 plus node number.
// R8: SDO responses go out on 1408 plus node number.
// R9: First PDO receives on 512 and transmits on 384 plus node.
// R10: Second PDO receives on 768 and transmits on 640 plus node.
// R11: Process input data is sent unprompted, unaddressed, unacknowledged.
// R12: SDO routing depends only on 16-bit index and 8-bit subindex; code also routes on the command specifier.
// R13: Indexes 2000h to 5EFFh go to the inverter control; code aborts unknown command specifiers locally.
// R14: A setting picks the one high-speed PDO channel.
// R15: After reset both PDOs are off and the first is high speed.
// R16: Low-speed PDO shares SDO priority.
// R17: High-speed output data goes as one process-data write service.
// R18: High-speed input data comes from one process-data read service.
// R19: High-speed path cycles at about 3 ms.
// R20: High-speed mapping is translated from inverter coding to CANopen.
// R21: Bit rate selectable among ten rates from 10 to 1000 kbit/s.
// R22: Inverter address defaults to 1.
// R23: Node starts pre-operational; PDOs wait for the start command.
// R24: SDO indexes outside the window are served locally.
// R25: Frames on other identifiers are ignored silently.
`timescale 1ns/100ps
module canopen_id_dispatch #(
    parameter int HS_CYCLE = canopen_dispatch_pkg::HS_CYCLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frames from the CAN controller
    input wire logic rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_data,
    // Frame to transmit through the CAN controller
    output logic tx_valid,
    output logic [10:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data,
    input wire logic tx_done,
    input wire logic tx_lost,
    // Network state commands decoded elsewhere
    input wire logic nmt_start,
    input wire logic nmt_preop,
    // Parameter services to the inverter control
    output logic par_req_valid,
    output logic par_req_write,
    output logic [15:0] par_index,
    output logic [7:0] par_sub,
    output logic [31:0] par_wdata,
    input wire logic par_ack,
    input wire logic [31:0] par_rdata,
    // Process-data services to the inverter control
    output logic pd_wr_valid,
    output logic [63:0] pd_wr_data,
    output logic pd_rd_req,
    input wire logic pd_rd_ack,
    input wire logic [63:0] pd_rd_data,
    input wire logic [15:0] hs_map_inv,
    // Settings seen by the controller
    output logic [3:0] bit_rate_sel,
    output logic operational
);
    import canopen_dispatch_pkg::*;

    typedef enum logic [1:0] {IDLE, FWD, RESP} eng_e;
    eng_e eng;

    logic [7:0] node_number_override;
    logic [7:0] inverter_address_setting;
    logic [2:0] pdo_ctrl;
    logic [15:0] ls_map;
    logic [18:0] hs_cnt;
    logic [2:0] cs;
    logic no_resp;
    logic [15:0] req_index;
    logic [7:0] req_sub;
    logic [31:0] req_value;
    logic [63:0] resp_data;
    logic pend_valid;
    logic [63:0] pend_data;
    logic retry;

    // Node number and identifiers
    wire [7:0] node = (node_number_override == OVERRIDE_USE_ADDR) ?
        8'(inverter_address_setting + 8'h01) : node_number_override; // R5 R6
    wire [10:0] node_w = {3'h0, node};
    wire [10:0] sdo_rx_id = SDO_RX_BASE + node_w; // R7
    wire [10:0] sdo_tx_id = SDO_TX_BASE + node_w; // R8
    wire [10:0] first_output_pdo_id = PDO1_RX_BASE + node_w; // R9
    wire [10:0] first_input_pdo_id = PDO1_TX_BASE + node_w; // R9
    wire [10:0] second_output_pdo_id = PDO2_RX_BASE + node_w; // R10
    wire [10:0] second_input_pdo_id = PDO2_TX_BASE + node_w; // R10

    // PDO control: [0] first on, [1] second on, [2] second is high speed
    wire en1 = pdo_ctrl[0];
    wire en2 = pdo_ctrl[1];
    wire hs_second = pdo_ctrl[2]; // R14
    wire hs_en = hs_second ? en2 : en1;
    wire [10:0] hs_tx_id = hs_second ? second_input_pdo_id : first_input_pdo_id;

    // Receive decode; other frames are dropped
    wire rx_ok = rx_valid && (rx_id <= ID_MAX) && (rx_dlc <= MAX_DLC); // R3 R4
    wire hit_sdo = rx_ok && (rx_id == sdo_rx_id); // R7 R25
    wire hit_p1 = rx_ok && operational && en1 && (rx_id == first_output_pdo_id); // R23
    wire hit_p2 = rx_ok && operational && en2 && (rx_id == second_output_pdo_id); // R23
    wire hs_hit = hs_second ? hit_p2 : hit_p1;
    wire ls_hit = hs_second ? hit_p1 : hit_p2;

    // SDO request fields
    wire [2:0] rx_cs = rx_data[7:5];
    wire [15:0] rx_index = rx_data[23:8]; // R12
    wire [7:0] rx_sub = rx_data[31:24]; // R12
    wire rx_fwd = (rx_index >= FWD_INDEX_LO) && (rx_index <= FWD_INDEX_HI); // R13
    wire cs_known = (rx_cs == CS_DOWNLOAD) || (rx_cs == CS_UPLOAD);
    wire sdo_take = (eng == IDLE) && hit_sdo;
    wire ls_take = (eng == IDLE) && !hit_sdo && ls_hit; // R16

    // Local object access
    wire [31:0] local_rd = (rx_sub == SUB_NODE) ? {24'h0, node} :
        (rx_sub == SUB_PDO) ? {29'h0, pdo_ctrl} :
        (rx_sub == SUB_RATE) ? {28'h0, bit_rate_sel} : 32'h0; // R24
    wire sdo_rate_wr = sdo_take && !rx_fwd && (rx_cs == CS_DOWNLOAD) &&
        (rx_sub == SUB_RATE) && (rx_data[35:32] <= RATE_CODE_MAX); // R21
    wire [63:0] local_resp = !cs_known ? {ABORT_CODE, rx_data[31:8], RESP_ABORT} :
        (rx_cs == CS_DOWNLOAD) ? {32'h0, rx_data[31:8], RESP_WRITE} :
        {local_rd, rx_data[31:8], RESP_READ};

    // Mapping in CANopen entry layout
    wire [31:0] hs_map_co = {16'(MAP_INDEX_BASE + hs_map_inv), 8'h00, MAP_BIT_LEN}; // R20

    // APB decode
    wire apb_acc = psel && penable && !pready;
    wire apb_wr = apb_acc && pwrite;
    wire addr_ok = (paddr == REG_NODE_OVR) || (paddr == REG_INV_ADDR) ||
        (paddr == REG_PDO_CTRL) || (paddr == REG_BIT_RATE) ||
        (paddr == REG_STATUS) || (paddr == REG_HS_MAP) || (paddr == REG_LS_MAP);
    wire [31:0] rd_mux = (paddr == REG_NODE_OVR) ? {24'h0, node_number_override} :
        (paddr == REG_INV_ADDR) ? {24'h0, inverter_address_setting} :
        (paddr == REG_PDO_CTRL) ? {29'h0, pdo_ctrl} :
        (paddr == REG_BIT_RATE) ? {28'h0, bit_rate_sel} :
        (paddr == REG_STATUS) ? {22'h0, (eng != IDLE), operational, node} :
        (paddr == REG_HS_MAP) ? hs_map_co :
        (paddr == REG_LS_MAP) ? {16'h0, ls_map} : 32'h0;
    wire rate_wr = apb_wr && (paddr == REG_BIT_RATE) && (pwdata[3:0] <= RATE_CODE_MAX);

    // SDO response goes before high-speed input data
    wire slot_free = !tx_valid && !retry;
    wire load_resp = slot_free && (eng == RESP);
    wire load_pd = slot_free && (eng != RESP) && pend_valid;
    wire hs_tick = (hs_cnt == 19'(HS_CYCLE - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apb_acc;
            pslverr <= apb_acc && !addr_ok;
            prdata <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            node_number_override <= RST_NODE_OVR;
            inverter_address_setting <= RST_INV_ADDR; // R22
            pdo_ctrl <= RST_PDO_CTRL; // R15
            bit_rate_sel <= RST_BIT_RATE;
            ls_map <= RST_LS_MAP;
        end else begin
            if (apb_wr && paddr == REG_NODE_OVR) node_number_override <= pwdata[7:0];
            if (apb_wr && paddr == REG_INV_ADDR) inverter_address_setting <= pwdata[7:0];
            if (apb_wr && paddr == REG_PDO_CTRL) pdo_ctrl <= pwdata[2:0]; // R14
            if (apb_wr && paddr == REG_LS_MAP) ls_map <= pwdata[15:0];
            if (sdo_rate_wr) bit_rate_sel <= rx_data[35:32]; // R21
            else if (rate_wr) bit_rate_sel <= pwdata[3:0]; // R21
        end
    end

    // Pre-operational until the start command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) operational <= 1'b0; // R23
        else if (nmt_preop) operational <= 1'b0;
        else if (nmt_start) operational <= 1'b1; // R23
    end

    // Request engine shared by SDO and low-speed PDO
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eng <= IDLE;
            cs <= 3'h0;
            no_resp <= 1'b0;
            req_index <= 16'h0;
            req_sub <= 8'h0;
            req_value <= 32'h0;
            resp_data <= 64'h0;
        end else begin
            case (eng)
                IDLE: begin
                    if (sdo_take) begin
                        cs <= rx_cs;
                        no_resp <= 1'b0;
                        req_index <= rx_index;
                        req_sub <= rx_sub;
                        req_value <= rx_data[63:32];
                        resp_data <= local_resp; // R24
                        eng <= (rx_fwd && cs_known) ? FWD : RESP; // R13
                    end else if (ls_take) begin
                        cs <= CS_DOWNLOAD;
                        no_resp <= 1'b1;
                        req_index <= ls_map;
                        req_sub <= 8'h00;
                        req_value <= rx_data[31:0];
                        eng <= FWD; // R16
                    end
                end
                FWD: begin
                    if (par_ack) begin
                        resp_data <= (cs == CS_DOWNLOAD) ?
                            {32'h0, req_sub, req_index, RESP_WRITE} :
                            {par_rdata, req_sub, req_index, RESP_READ};
                        eng <= no_resp ? IDLE : RESP;
                    end
                end
                RESP: begin
                    if (load_resp) eng <= IDLE;
                end
                default: eng <= IDLE;
            endcase
        end
    end

    // Parameter request, held until acknowledged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            par_req_valid <= 1'b0;
            par_req_write <= 1'b0;
            par_index <= 16'h0;
            par_sub <= 8'h0;
            par_wdata <= 32'h0;
        end else if (eng == IDLE && ((sdo_take && rx_fwd && cs_known) || ls_take)) begin
            par_req_valid <= 1'b1; // R13
            par_req_write <= ls_take || (rx_cs == CS_DOWNLOAD);
            par_index <= ls_take ? ls_map : rx_index;
            par_sub <= ls_take ? 8'h00 : rx_sub;
            par_wdata <= ls_take ? rx_data[31:0] : rx_data[63:32];
        end else if (par_ack) begin
            par_req_valid <= 1'b0;
        end
    end

    // One process-data write per high-speed frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_wr_valid <= 1'b0;
            pd_wr_data <= 64'h0;
        end else begin
            pd_wr_valid <= hs_hit; // R17
            if (hs_hit) pd_wr_data <= rx_data;
        end
    end

    // One high-speed read service per period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_cnt <= 19'h0;
            pd_rd_req <= 1'b0;
            pend_valid <= 1'b0;
            pend_data <= 64'h0;
        end else begin
            hs_cnt <= hs_tick ? 19'h0 : 19'(hs_cnt + 19'h1); // R19
            if (hs_tick && operational && hs_en && !pend_valid) pd_rd_req <= 1'b1; // R18
            else if (pd_rd_ack) pd_rd_req <= 1'b0;
            if (pd_rd_req && pd_rd_ack) begin
                pend_valid <= 1'b1;
                pend_data <= pd_rd_data;
            end else if (load_pd) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Lost arbitration withdraws the frame for one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_id <= 11'h0;
            tx_dlc <= 4'h0;
            tx_data <= 64'h0;
            retry <= 1'b0;
        end else if (tx_valid && tx_lost) begin
            tx_valid <= 1'b0; // R2
            retry <= 1'b1;
        end else if (retry) begin
            tx_valid <= 1'b1; // R1
            retry <= 1'b0;
        end else if (tx_valid && tx_done) begin
            tx_valid <= 1'b0; // R1
        end else if (load_resp) begin
            tx_valid <= 1'b1;
            tx_id <= sdo_tx_id; // R8
            tx_dlc <= MAX_DLC; // R4
            tx_data <= resp_data;
        end else if (load_pd) begin
            tx_valid <= 1'b1; // R11
            tx_id <= hs_tx_id; // R9 R10
            tx_dlc <= MAX_DLC;
            tx_data <= pend_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sdo_resp_id: assert property (load_resp |=> tx_valid && tx_id == sdo_tx_id) // R8
        else $error("SDO response identifier wrong");
    a_node_from_addr: assert property (node_number_override == 8'hFF // R5
        |-> node == 8'(inverter_address_setting + 8'h01))
        else $error("Node not taken from address");
    a_node_direct: assert property (node_number_override != 8'hFF // R6
        |-> node == node_number_override)
        else $error("Override not used");
    a_fwd_window: assert property ($rose(par_req_valid) && !no_resp // R13
        |-> par_index >= 16'h2000 && par_index <= 16'h5EFF)
        else $error("Forward outside window");
    a_local_stays: assert property (sdo_take && !rx_fwd |=> eng == RESP && !par_req_valid) // R24
        else $error("Local request forwarded");
    a_preop_no_pdo: assert property (!$past(operational) // R23
        |-> !pd_wr_valid && !$rose(pd_rd_req))
        else $error("Process data in preop");
    a_lost_drop: assert property (tx_valid && tx_lost |=> !tx_valid ##1 tx_valid) // R2
        else $error("Lost frame not re-offered");
    a_hs_write: assert property (hs_hit |=> pd_wr_valid && pd_wr_data == $past(rx_data)) // R17
        else $error("HS data not written");
    a_bad_id_drop: assert property (rx_valid && (rx_id > 11'h7EF || rx_dlc > 4'h8) // R3 R4
        |-> !hit_sdo && !hs_hit)
        else $error("Bad frame accepted");
    a_rate_range: assert property (bit_rate_sel <= 4'h9) // R21
        else $error("Bit rate out of range");
endmodule : canopen_id_dispatch

// ==== tb/can_master_model.sv ====
/*
 * CAN master model: takes each offered frame, loses arbitration
 * once per frame while lose_next is high. Assumes the node's clock and reset.
 */
`timescale 1ns/100ps
module can_master_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Frame offered by the node
    input wire logic tx_valid,
    input wire logic [10:0] tx_id,
    input wire logic [63:0] tx_data,
    input wire logic lose_next,
    output logic tx_done,
    output logic tx_lost,
    // Last frame taken off the bus
    output logic got,
    output logic [10:0] got_id,
    output logic [63:0] got_data
);
    logic [1:0] cnt;
    logic lost_once;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            lost_once <= 1'b0;
            tx_done <= 1'b0;
            tx_lost <= 1'b0;
            got <= 1'b0;
            got_id <= 11'h000;
            got_data <= 64'h0;
        end else begin
            tx_done <= 1'b0;
            tx_lost <= 1'b0;
            got <= 1'b0;
            if (tx_valid && !tx_done && !tx_lost) begin
                cnt <= cnt + 2'h1;
                if (cnt == 2'h3 && lose_next && !lost_once) begin
                    tx_lost <= 1'b1;
                    lost_once <= 1'b1;
                end else if (cnt == 2'h3) begin
                    tx_done <= 1'b1;
                    got <= 1'b1;
                    got_id <= tx_id;
                    got_data <= tx_data;
                    lost_once <= 1'b0;
                end
            end else begin
                cnt <= 2'h0;
            end
        end
    end
endmodule : can_master_model

// ==== tb/tb_canopen_id_dispatch.sv ====
/*
 * Bench of the dispatch block with inverter responder and CAN master.
 * Assumes one 125 MHz clock.
 */
`timescale 1ns/100ps
module tb_canopen_id_dispatch;
    import canopen_dispatch_pkg::*;
    localparam logic [31:0] PAR_VAL = 32'h1234_ABCD;
    localparam logic [63:0] PD_VAL = 64'h0102_0304_A5B6_C7D8;
    localparam logic [7:0] RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    localparam logic [31:0] RE [8] = '{32'hFF, 32'h1, 32'h0, 32'h5, 32'h2, 32'h2010_0020,
        32'h2000, 32'h0};
    localparam logic [15:0] IX [4] = '{16'h1FFF, 16'h5F00, 16'h2000, 16'h5EFF};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, par_sub;
    logic [31:0] pwdata = 32'h0, prdata, par_wdata, par_rdata, p_wd = 32'h0;
    logic pready, pslverr, rx_valid = 1'b0, tx_valid, tx_done, tx_lost, lose_next = 1'b0;
    logic [10:0] rx_id = 11'h000, tx_id, got_id;
    logic [3:0] rx_dlc = 4'h8, tx_dlc, bit_rate_sel;
    logic [63:0] rx_data = 64'h0, tx_data, got_data, pd_wr_data, pd_rd_data, wr_last = 64'h0;
    logic nmt_start = 1'b0, nmt_preop = 1'b0, par_req_valid, par_req_write, par_ack = 1'b0;
    logic [15:0] par_index, p_idx = 16'h0, hs_map_inv = 16'h0010;
    logic pd_wr_valid, pd_rd_req, pd_rd_ack = 1'b0, operational, got, p_wr = 1'b0;
    int failures = 0, comparisons = 0, wr_cnt = 0, p_cnt = 0, losses = 0;

    canopen_id_dispatch #(.HS_CYCLE(50)) canopen_id_dispatch_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
        .tx_done(tx_done), .tx_lost(tx_lost), .nmt_start(nmt_start), .nmt_preop(nmt_preop),
        .par_req_valid(par_req_valid), .par_req_write(par_req_write), .par_index(par_index),
        .par_sub(par_sub), .par_wdata(par_wdata), .par_ack(par_ack), .par_rdata(par_rdata),
        .pd_wr_valid(pd_wr_valid), .pd_wr_data(pd_wr_data), .pd_rd_req(pd_rd_req),
        .pd_rd_ack(pd_rd_ack), .pd_rd_data(pd_rd_data), .hs_map_inv(hs_map_inv),
        .bit_rate_sel(bit_rate_sel), .operational(operational));
    can_master_model can_master_model_inst (.clk(clk), .rst(rst), .tx_valid(tx_valid),
        .tx_id(tx_id), .tx_data(tx_data), .lose_next(lose_next), .tx_done(tx_done),
        .tx_lost(tx_lost), .got(got), .got_id(got_id), .got_data(got_data));

    always #4 clk = ~clk;
    // Data lines invalid outside ack
    assign par_rdata = par_ack ? PAR_VAL : ~PAR_VAL;
    assign pd_rd_data = pd_rd_ack ? PD_VAL : ~PD_VAL;

    // Inverter control acks one cycle later
    always @(posedge clk) begin
        par_ack <= par_req_valid && !par_ack;
        pd_rd_ack <= pd_rd_req && !pd_rd_ack;
        if (par_req_valid === 1'b1 && !par_ack) begin
            p_idx <= par_index;
            p_wr <= par_req_write;
            p_wd <= par_wdata;
            p_cnt <= p_cnt + 1;
        end
        if (pd_wr_valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= pd_wr_data;
        end
        if (tx_lost === 1'b1) losses <= losses + 1;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic send(input logic [10:0] id, input logic [63:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_data <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask : send

    function automatic logic [63:0] sdo(input logic [7:0] c, input logic [15:0] ix,
        input logic [7:0] sub, input logic [31:0] d);
        return {d, sub, ix, c};
    endfunction : sdo

    task automatic wait_frame(input logic [10:0] id, input logic [7:0] b0, input string nm);
        @(posedge clk);
        while (!(got === 1'b1 && got_id === id)) @(posedge clk);
        chk({nm, " id"}, {53'h0, id}, {53'h0, got_id});
        chk({nm, " byte0"}, {56'h0, b0}, {56'h0, got_data[7:0]});
    endtask : wait_frame

    task automatic quiet(input string nm);
        int n = 0;
        repeat (30) begin
            @(posedge clk);
            if (tx_valid === 1'b1 || pd_wr_valid === 1'b1) n++;
        end
        chk(nm, 64'h0, n);
    endtask : quiet

    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        failures++;
        complete_run();
    end

    initial begin
        logic [31:0] rd;
        logic err;
        int n0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, RA[i], 32'h0, rd, err);
            chk("register", {32'h0, RE[i]}, {32'h0, rd});
            chk("slverr", {63'h0, i == 7}, {63'h0, err});
        end
        chk("bit rate", 64'h5, {60'h0, bit_rate_sel});
        $display("test reset values done");
        send(SDO_RX_BASE + 11'h2, sdo(8'h40, 16'h1000, SUB_NODE, 32'h0));
        wait_frame(SDO_TX_BASE + 11'h2, RESP_READ, "local read");
        chk("node object", 64'h2, {56'h0, got_data[39:32]});
        send(SDO_RX_BASE + 11'h3, sdo(8'h40, 16'h1000, SUB_NODE, 32'h0));
        rx_dlc <= 4'h9;
        send(SDO_RX_BASE + 11'h2, 64'h40);
        rx_dlc <= 4'h8;
        quiet("foreign id");
        send(SDO_RX_BASE + 11'h2, sdo(8'hE0, 16'h1000, SUB_NODE, 32'h0));
        wait_frame(SDO_TX_BASE + 11'h2, RESP_ABORT, "abort");
        for (int i = 0; i < 4; i++) begin
            n0 = p_cnt;
            send(SDO_RX_BASE + 11'h2, sdo(8'h40, IX[i], 8'h01, 32'h0));
            wait_frame(SDO_TX_BASE + 11'h2, RESP_READ, "index read");
            chk("forwarded", {63'h0, i > 1}, {63'h0, p_cnt != n0});
        end
        chk("forward data", {32'h0, PAR_VAL}, {32'h0, got_data[63:32]});
        chk("forward index", 64'h5EFF, {48'h0, p_idx});
        send(SDO_RX_BASE + 11'h2, sdo(8'h23, 16'h2000, 8'h00, 32'h1234));
        wait_frame(SDO_TX_BASE + 11'h2, RESP_WRITE, "forward write");
        chk("write data", 64'h1234, {32'h0, p_wd});
        chk("write flag", 64'h1, {63'h0, p_wr});
        $display("test sdo routing done");
        send(SDO_RX_BASE + 11'h2, sdo(8'h23, 16'h1000, SUB_RATE, 32'h9));
        wait_frame(SDO_TX_BASE + 11'h2, RESP_WRITE, "rate write");
        chk("rate sel", 64'h9, {60'h0, bit_rate_sel});
        apb(1'b1, REG_BIT_RATE, 32'hA, rd, err);
        apb(1'b0, REG_BIT_RATE, 32'h0, rd, err);
        chk("rate refused", 64'h9, {32'h0, rd});
        apb(1'b1, REG_NODE_OVR, 32'h1E, rd, err);
        send(SDO_RX_BASE + 11'h1E, sdo(8'h40, 16'h1000, SUB_NODE, 32'h0));
        wait_frame(SDO_TX_BASE + 11'h1E, RESP_READ, "override node");
        apb(1'b1, REG_NODE_OVR, 32'hFF, rd, err);
        apb(1'b1, REG_INV_ADDR, 32'h4, rd, err);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk("address node", 64'h5, {56'h0, rd[7:0]});
        $display("test node number done");
        apb(1'b1, REG_PDO_CTRL, 32'h3, rd, err);
        send(PDO1_RX_BASE + 11'h5, 64'h11);
        quiet("preop pdo");
        nmt_start <= 1'b1;
        @(posedge clk);
        nmt_start <= 1'b0;
        send(PDO1_RX_BASE + 11'h5, 64'hDEAD_BEEF_0000_0001);
        repeat (8) @(posedge clk);
        chk("operational", 64'h1, {63'h0, operational});
        chk("hs writes", 64'h1, wr_cnt);
        chk("hs data", 64'hDEAD_BEEF_0000_0001, wr_last);
        send(PDO2_RX_BASE + 11'h5, 64'h5A5A);
        repeat (8) @(posedge clk);
        chk("ls index", 64'h2000, {48'h0, p_idx});
        chk("ls data", 64'h5A5A, {32'h0, p_wd});
        wait_frame(PDO1_TX_BASE + 11'h5, PD_VAL[7:0], "hs input");
        chk("hs input data", PD_VAL, got_data);
        $display("test first channel done");
        apb(1'b1, REG_PDO_CTRL, 32'h7, rd, err);
        send(PDO2_RX_BASE + 11'h5, 64'h77);
        repeat (8) @(posedge clk);
        chk("second hs", 64'h77, wr_last);
        lose_next <= 1'b1;
        wait_frame(PDO2_TX_BASE + 11'h5, PD_VAL[7:0], "second input");
        lose_next <= 1'b0;
        chk("lost", 64'h1, {63'h0, losses != 0});
        nmt_preop <= 1'b1;
        @(posedge clk);
        nmt_preop <= 1'b0;
        @(posedge clk);
        chk("preop", 64'h0, {63'h0, operational});
        $display("test second channel done");
        complete_run();
    end
endmodule : tb_canopen_id_dispatch
